/* peripheral_soft_reset_regs.sv */
// Contract
// - Port register writes change only bits whose fourth capability bit is set.
// - The port register decodes at offset 0x048 and clears to zero on reset.
// - Port register bits 0 to 7 are read/write and reset ports A to H.
// - Port register bits 31 to 8 read zero and ignore writes.
// - Bit 8 of the first peripheral register resets the quadrature encoder.
// - Bit 4 of the first peripheral register resets the synchronous serial unit.
// - Bits 2, 1 and 0 of that register reset asynchronous serial units 2, 1 and 0.
// - Bits 7 to 5 and 3 of that register are reserved, read zero and reset to zero.
// - The first peripheral register decodes at 0x044, resets to zero, masked by cap two.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module peripheral_soft_reset_regs (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Device capability masks
  input  wire logic [31:0] capability_mask_two,
  input  wire logic [31:0] capability_mask_four,
  // Port reset lines
  output logic             port_a_reset,
  output logic             port_b_reset,
  output logic             port_c_reset,
  output logic             port_d_reset,
  output logic             port_e_reset,
  output logic             port_f_reset,
  output logic             port_g_reset,
  output logic             port_h_reset,
  // Serial and encoder reset lines
  output logic             quad_encoder_reset,
  output logic             sync_serial_reset,
  output logic             async_serial0_reset,
  output logic             async_serial1_reset,
  output logic             async_serial2_reset
);

  // ==========================================================================
  // Register instances
  ctrl_reg_if #(.WIDTH(peripheral_reset_pkg::DATA_WIDTH)) periph_one_if ();
  ctrl_reg_if #(.WIDTH(peripheral_reset_pkg::DATA_WIDTH)) gpio_port_if ();

  masked_ctrl_reg #(
    .WIDTH       (peripheral_reset_pkg::DATA_WIDTH),
    .RESET_VALUE (peripheral_reset_pkg::PERIPH_ONE_RESET),
    .WRITABLE    (peripheral_reset_pkg::PERIPH_ONE_WRITABLE)
  ) u_periph_one (
    .pclk    (pclk),
    .presetn (presetn),
    .ctrl    (periph_one_if.reg_side)
  );

  masked_ctrl_reg #(
    .WIDTH       (peripheral_reset_pkg::DATA_WIDTH),
    .RESET_VALUE (peripheral_reset_pkg::GPIO_PORT_RESET),
    .WRITABLE    (peripheral_reset_pkg::GPIO_PORT_WRITABLE)
  ) u_gpio_port (
    .pclk    (pclk),
    .presetn (presetn),
    .ctrl    (gpio_port_if.reg_side)
  );

  // ==========================================================================
  // Address decode and phase tracking
  wire logic        setup_phase;
  wire logic        access_done;
  wire logic        hit_periph_one;
  wire logic        hit_gpio_port;
  wire logic        addr_mapped;
  wire logic        write_commit;
  wire logic [31:0] lane_bits;
  wire logic [31:0] read_value;

  assign setup_phase    = psel & ~penable;
  assign access_done    = psel & penable & pready;
  assign hit_periph_one = (paddr == peripheral_reset_pkg::PERIPH_ONE_OFFSET);
  assign hit_gpio_port  = (paddr == peripheral_reset_pkg::GPIO_PORT_OFFSET);
  assign addr_mapped    = hit_periph_one | hit_gpio_port;
  assign write_commit   = access_done & pwrite;

  // Byte strobes widened to one enable per data bit
  assign lane_bits = {{peripheral_reset_pkg::LANE_WIDTH{pstrb[3]}},
                      {peripheral_reset_pkg::LANE_WIDTH{pstrb[2]}},
                      {peripheral_reset_pkg::LANE_WIDTH{pstrb[1]}},
                      {peripheral_reset_pkg::LANE_WIDTH{pstrb[0]}}};

  // ==========================================================================
  // Write path into the registers
  assign periph_one_if.write_en    = write_commit & hit_periph_one;
  assign periph_one_if.write_data  = pwdata;
  assign periph_one_if.write_lanes = lane_bits;
  assign periph_one_if.cap_mask    = capability_mask_two;

  assign gpio_port_if.write_en     = write_commit & hit_gpio_port;
  assign gpio_port_if.write_data   = pwdata;
  assign gpio_port_if.write_lanes  = lane_bits;
  assign gpio_port_if.cap_mask     = capability_mask_four;

  // ==========================================================================
  // Read selection; fixed bits are masked so reserved positions read zero
  assign read_value =
    hit_periph_one ? (periph_one_if.value & peripheral_reset_pkg::PERIPH_ONE_WRITABLE) :
    hit_gpio_port  ? (gpio_port_if.value & peripheral_reset_pkg::GPIO_PORT_WRITABLE) :
                     peripheral_reset_pkg::READ_IDLE;

  // ==========================================================================
  // APB response, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= setup_phase & ~addr_mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= peripheral_reset_pkg::READ_IDLE;
    end else if (setup_phase) begin
      prdata <= pwrite ? peripheral_reset_pkg::READ_IDLE : read_value;
    end
  end

  // ==========================================================================
  // Reset lines follow the stored bits directly
  assign port_a_reset = gpio_port_if.value[peripheral_reset_pkg::PORT_A_BIT];
  assign port_b_reset = gpio_port_if.value[peripheral_reset_pkg::PORT_B_BIT];
  assign port_c_reset = gpio_port_if.value[peripheral_reset_pkg::PORT_C_BIT];
  assign port_d_reset = gpio_port_if.value[peripheral_reset_pkg::PORT_D_BIT];
  assign port_e_reset = gpio_port_if.value[peripheral_reset_pkg::PORT_E_BIT];
  assign port_f_reset = gpio_port_if.value[peripheral_reset_pkg::PORT_F_BIT];
  assign port_g_reset = gpio_port_if.value[peripheral_reset_pkg::PORT_G_BIT];
  assign port_h_reset = gpio_port_if.value[peripheral_reset_pkg::PORT_H_BIT];

  assign quad_encoder_reset =
    periph_one_if.value[peripheral_reset_pkg::QUAD_ENCODER_BIT];
  assign sync_serial_reset =
    periph_one_if.value[peripheral_reset_pkg::SYNC_SERIAL_BIT];
  assign async_serial0_reset =
    periph_one_if.value[peripheral_reset_pkg::ASYNC_SERIAL0_BIT];
  assign async_serial1_reset =
    periph_one_if.value[peripheral_reset_pkg::ASYNC_SERIAL1_BIT];
  assign async_serial2_reset =
    periph_one_if.value[peripheral_reset_pkg::ASYNC_SERIAL2_BIT];

endmodule

`default_nettype wire

/* peripheral_reset_pkg.sv */
package peripheral_reset_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_WIDTH = 12;
  localparam int DATA_WIDTH = 32;
  localparam int LANE_WIDTH = 8;
  localparam int LANE_COUNT = 4;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] PERIPH_ONE_OFFSET = 12'h044;
  localparam logic [11:0] GPIO_PORT_OFFSET  = 12'h048;

  // ==========================================================================
  // Reset values and writable bit masks
  localparam logic [31:0] PERIPH_ONE_RESET    = 32'h0000_0000;
  localparam logic [31:0] GPIO_PORT_RESET     = 32'h0000_0000;
  localparam logic [31:0] PERIPH_ONE_WRITABLE = 32'h0000_0117;
  localparam logic [31:0] GPIO_PORT_WRITABLE  = 32'h0000_00ff;
  localparam logic [31:0] READ_IDLE           = 32'h0000_0000;

  // ==========================================================================
  // Field positions in the first peripheral reset register
  localparam int QUAD_ENCODER_BIT  = 8;
  localparam int SYNC_SERIAL_BIT   = 4;
  localparam int ASYNC_SERIAL2_BIT = 2;
  localparam int ASYNC_SERIAL1_BIT = 1;
  localparam int ASYNC_SERIAL0_BIT = 0;

  // ==========================================================================
  // Field positions in the port reset register
  localparam int PORT_A_BIT = 0;
  localparam int PORT_B_BIT = 1;
  localparam int PORT_C_BIT = 2;
  localparam int PORT_D_BIT = 3;
  localparam int PORT_E_BIT = 4;
  localparam int PORT_F_BIT = 5;
  localparam int PORT_G_BIT = 6;
  localparam int PORT_H_BIT = 7;

endpackage

/* ctrl_reg_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface ctrl_reg_if #(
  parameter int WIDTH = 32
);
  logic             write_en;
  logic [WIDTH-1:0] write_data;
  logic [WIDTH-1:0] write_lanes;
  logic [WIDTH-1:0] cap_mask;
  logic [WIDTH-1:0] value;

  modport bus_side (
    output write_en,
    output write_data,
    output write_lanes,
    output cap_mask,
    input  value
  );

  modport reg_side (
    input  write_en,
    input  write_data,
    input  write_lanes,
    input  cap_mask,
    output value
  );
endinterface

`default_nettype wire

/* masked_ctrl_reg.sv */
`timescale 1ns/1ps
`default_nettype none

module masked_ctrl_reg #(
  parameter int               WIDTH       = 32,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0,
  parameter logic [WIDTH-1:0] WRITABLE    = '0
) (
  // Clock and reset
  input wire logic    pclk,
  input wire logic    presetn,
  // Register access
  ctrl_reg_if.reg_side ctrl
);

  // ==========================================================================
  // Per-bit storage
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic      bit_q;
    wire logic bit_en;

    // Capability mask and byte lane gate each bit; fixed bits never change
    assign bit_en = WRITABLE[i] & ctrl.cap_mask[i] & ctrl.write_lanes[i];

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        bit_q <= RESET_VALUE[i];
      end else if (ctrl.write_en && bit_en) begin
        bit_q <= ctrl.write_data[i];
      end
    end

    assign ctrl.value[i] = bit_q;
  end

endmodule

`default_nettype wire

/* peripheral_soft_reset_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module peripheral_soft_reset_assertions (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Capability masks
  input wire logic [31:0] capability_mask_two,
  input wire logic [31:0] capability_mask_four,
  // Reset lines
  input wire logic        port_a_reset,
  input wire logic        port_b_reset,
  input wire logic        port_c_reset,
  input wire logic        port_d_reset,
  input wire logic        port_e_reset,
  input wire logic        port_f_reset,
  input wire logic        port_g_reset,
  input wire logic        port_h_reset,
  input wire logic        quad_encoder_reset,
  input wire logic        sync_serial_reset,
  input wire logic        async_serial0_reset,
  input wire logic        async_serial1_reset,
  input wire logic        async_serial2_reset
);
  // ==========================================================================
  // Reset lines gathered at their register positions
  wire logic [31:0] pv = {24'h0, port_h_reset, port_g_reset, port_f_reset, port_e_reset,
                          port_d_reset, port_c_reset, port_b_reset, port_a_reset};
  wire logic [31:0] ov = {23'h0, quad_encoder_reset, 3'h0, sync_serial_reset, 1'b0,
                          async_serial2_reset, async_serial1_reset, async_serial0_reset};
  wire logic        acc = psel & penable & pready;
  wire logic        at1 = (paddr == 12'h044);
  wire logic        at2 = (paddr == 12'h048);

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Properties
  AST_ANSWER: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  AST_PORT_READ: assert property (acc && at2 && !pwrite |-> prdata == pv)
    else $error("port register read differs from reset lines");
  AST_PORT_RSVD: assert property (acc && at2 |-> prdata[31:8] == 24'h0)
    else $error("port register upper bits not zero");
  AST_ONE_READ: assert property (acc && at1 && !pwrite |-> prdata == ov)
    else $error("peripheral register read differs from reset lines");
  AST_ONE_RSVD: assert property (acc && at1 |-> (prdata & ~32'h0000_0117) == 32'h0)
    else $error("peripheral register reserved bits not zero");
  AST_UNMAPPED: assert property (acc && !at1 && !at2
    |-> pslverr && prdata == 32'h0 ##1 $stable(pv) && $stable(ov))
    else $error("unmapped access not refused");
  AST_PORT_WRITE: assert property (acc && at2 && pwrite && pstrb[0] |=>
    pv == (($past(pwdata) & $past(capability_mask_four) |
            $past(pv) & ~$past(capability_mask_four)) & 32'h0000_00ff))
    else $error("port register write not masked by capability");
  AST_ONE_WRITE: assert property (acc && at1 && pwrite && pstrb[1:0] == 2'h3 |=>
    ov == (($past(pwdata) & $past(capability_mask_two) |
            $past(ov) & ~$past(capability_mask_two)) & 32'h0000_0117))
    else $error("peripheral register write not masked by capability");
  AST_HOLD: assert property (!(acc && pwrite) |=> $stable(pv) && $stable(ov))
    else $error("reset line changed without a write");
endmodule
bind peripheral_soft_reset_regs peripheral_soft_reset_assertions chk (.*);
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, capability_mask_two = 32'h0, capability_mask_four = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, quad_encoder_reset, sync_serial_reset;
  wire logic async_serial0_reset, async_serial1_reset, async_serial2_reset;
  wire logic port_a_reset, port_b_reset, port_c_reset, port_d_reset;
  wire logic port_e_reset, port_f_reset, port_g_reset, port_h_reset;
  logic [31:0] rdata;
  logic        rerr;
  int          num_errors = 0;
  int          cmp_count = 0;
  wire logic [31:0] pv = {24'h0, port_h_reset, port_g_reset, port_f_reset, port_e_reset,
                          port_d_reset, port_c_reset, port_b_reset, port_a_reset};
  wire logic [31:0] ov = {23'h0, quad_encoder_reset, 3'h0, sync_serial_reset, 1'b0,
                          async_serial2_reset, async_serial1_reset, async_serial0_reset};

  peripheral_soft_reset_regs dut (.*);

  always #25 pclk = ~pclk;

  // ==========================================================================
  // APB transfer, ends one idle cycle after the answer
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) num_errors++;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input logic [11:0] a, input string nm, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0, 4'hf);
    chk(nm, e, rdata);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    final_report();
  end

  // ==========================================================================
  // Tests
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h044, "periph reset value", 32'h0);
    rd(12'h048, "port reset value", 32'h0);
    chk("port lines at reset", 32'h0, pv);
    chk("periph lines at reset", 32'h0, ov);
    $display("reset values done");
    capability_mask_four <= 32'hffff_ffff;
    xfer(12'h048, 1'b1, 32'hffff_ffff, 4'hf);
    rd(12'h048, "port all set", 32'h0000_00ff);
    chk("port lines", 32'h0000_00ff, pv);
    capability_mask_four <= 32'h0000_000f;
    xfer(12'h048, 1'b1, 32'h0, 4'hf);
    rd(12'h048, "port masked", 32'h0000_00f0);
    capability_mask_four <= 32'h0000_00ff;
    xfer(12'h048, 1'b1, 32'h0, 4'he);
    rd(12'h048, "port lane off", 32'h0000_00f0);
    xfer(12'h048, 1'b1, 32'h0, 4'hf);
    chk("port released", 32'h0, pv);
    $display("port register done");
    capability_mask_two <= 32'hffff_ffff;
    xfer(12'h044, 1'b1, 32'hffff_ffff, 4'hf);
    rd(12'h044, "periph all set", 32'h0000_0117);
    chk("periph lines", 32'h0000_0117, ov);
    capability_mask_two <= 32'hffff_ffef;
    xfer(12'h044, 1'b1, 32'h0, 4'hf);
    rd(12'h044, "periph masked", 32'h0000_0010);
    xfer(12'h045, 1'b1, 32'h0, 4'hf);
    chk("misaligned error", 32'h1, {31'h0, rerr});
    rd(12'h04c, "unmapped read", 32'h0);
    chk("unmapped error", 32'h1, {31'h0, rerr});
    chk("periph kept", 32'h0000_0010, ov);
    $display("periph register done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("port lines after reset", 32'h0, pv);
    chk("periph lines after reset", 32'h0, ov);
    rd(12'h044, "periph after reset", 32'h0);
    $display("second reset done");
    final_report();
  end
endmodule
`default_nettype wire
